// ===== bench/slj_link_assertions.sv
/* checker for the link carrier: frame layout, status bits and register readback.
   assumes one mclk, rst_b async low, full counts held fixed at the parameters. */
`timescale 1ns/1ps
`default_nettype none
`include "slj_map.svh"
module slj_link_checker #(
	parameter int FULL_L = 5,
	parameter int FULL_M = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// host port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// sync line and frame layout
	input wire logic sync_n,
	input wire logic [3:0] lane_count,
	input wire logic [3:0] conv_count,
	input wire logic tail_bits,
	input wire logic pair_swap
);
	logic [7:0] ch_q; // shadow of the channel enable byte
	logic [7:0] chd_q; // same, one edge later, as the layout lags the register
	logic [7:0] sh_q; // shadow of the sync header byte
	logic live_q; // layout outputs hold reset zeros until the first edge
	logic red; // a pair is off or single mode is on
	logic [3:0] fl;
	logic [3:0] fm;
	assign fl = 4'(FULL_L);
	assign fm = 4'(FULL_M);
	assign red = chd_q[2] | !chd_q[0] | !chd_q[1];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// follow host writes the way the converter end stores them
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ch_q <= `SLJ_CHANNEL_ENABLE_CTRL_RST;
			chd_q <= `SLJ_CHANNEL_ENABLE_CTRL_RST;
			sh_q <= `SLJ_SH_MODE_RST;
			live_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `SLJ_OFS_CHANNEL_ENABLE_CTRL) ch_q <= reg_wdata;
			if (reg_wr && reg_addr == `SLJ_OFS_SH_MODE) sh_q <= reg_wdata;
			chd_q <= ch_q;
			live_q <= 1'b1;
		end
	end
	lane_scale_a: assert property (live_q |-> lane_count == (red ? (fl + 4'h1) >> 1 : fl))
		else $error("lane count does not match channel enable");
	conv_scale_a: assert property (live_q |-> conv_count == (red ? fm >> 1 : fm))
		else $error("converter count does not match channel enable");
	tail_pad_a: assert property (live_q |-> tail_bits == (red & fl[0]))
		else $error("tail bit flag wrong");
	pair_move_a: assert property (live_q |-> pair_swap == (!chd_q[2] & !chd_q[0] & chd_q[1]))
		else $error("pair swap flag wrong");
	sync_bit_a: assert property ((reg_rd && reg_addr == `SLJ_OFS_LINK_STATUS
		&& $stable(sync_n) && sync_n == $past(sync_n, 2) && sync_n == $past(sync_n, 4))
		|=> reg_rdata[5] == $past(sync_n)) else $error("sync state bit wrong");
	link_down_a: assert property ((reg_rd && reg_addr == `SLJ_OFS_LINK_STATUS && !sync_n
		&& !$past(sync_n) && !$past(sync_n, 2) && !$past(sync_n, 3) && !$past(sync_n, 4))
		|=> !reg_rdata[6]) else $error("link up while sync asserted");
	ch_readback_a: assert property (reg_rd && reg_addr == `SLJ_OFS_CHANNEL_ENABLE_CTRL
		|=> reg_rdata == $past(ch_q)) else $error("channel enable readback wrong");
	sh_readback_a: assert property (reg_rd && reg_addr == `SLJ_OFS_SH_MODE
		|=> reg_rdata == $past(sh_q)) else $error("sync header readback wrong");
endmodule
`default_nettype wire

// ===== bench/testbench.sv
/* testbench joining both link ends: modes, sync header codes, live status bits.
   assumes the two ends and the carrier elaborate from verilog/. */
`timescale 1ns/1ps
`default_nettype none
`include "slj_map.svh"
module testbench;
	import slj_pkg::*;
	localparam int FULL_L = 5; // odd, so tail padding shows
	localparam int FULL_M = 4;
	logic mclk, rst_b, spll, cpll, realign, sevent, is66, cmd_valid, cmd_link_on, rx_locked;
	slj_op_t cmd_op;
	slj_mode_t cmd_mode;
	logic [1:0] cmd_sh;
	logic [11:0] cmd_addr;
	logic busy_q, refused_q, rd_valid_q, one_q, len_q, cal_q, crc_q, fec_q, irq_q;
	logic [7:0] rd_data_q;
	logic [3:0] chan_q, lane_q, conv_q;
	logic tail_q, swap_q;
	int err_total, checks_done;
	slj_if link_if ();
	slj_dev_end slj_dev_end_i (.mclk(mclk), .rst_b(rst_b), .link(link_if),
		.serializer_pll_lock(spll), .sampling_pll_lock(cpll), .sysref_realign(realign),
		.sysref_event(sevent), .full_lane_count(4'(FULL_L)), .full_converter_count(4'(FULL_M)),
		.mode_is_64b66b(is66), .chan_enable_q(chan_q), .one_channel_mode_enable_q(one_q),
		.link_enable_q(len_q), .cal_enable_q(cal_q), .send_crc12_q(crc_q), .send_fec_q(fec_q),
		.irq_q(irq_q));
	slj_rx_end slj_rx_end_i (.mclk(mclk), .rst_b(rst_b), .link(link_if), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_mode(cmd_mode), .cmd_sync_header(cmd_sh),
		.cmd_link_on(cmd_link_on), .cmd_addr(cmd_addr), .rx_locked(rx_locked), .busy_q(busy_q),
		.refused_q(refused_q), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
		.lane_count_q(lane_q), .conv_count_q(conv_q), .tail_bits_q(tail_q), .pair_swap_q(swap_q));
	slj_link_checker #(.FULL_L(FULL_L), .FULL_M(FULL_M)) slj_link_checker_i (.mclk(mclk),
		.rst_b(rst_b), .reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata),
		.reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd), .reg_rdata(link_if.reg_rdata),
		.sync_n(link_if.sync_n), .lane_count(link_if.lane_count),
		.conv_count(link_if.conv_count), .tail_bits(link_if.tail_bits),
		.pair_swap(link_if.pair_swap));
	// verdict and end of run
	task automatic end_sim();
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// one comparison, narrower results zero-extended
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one user command; f = {read answered, refused}, then waits for idle
	task automatic issue(input slj_op_t op, input slj_mode_t md, input logic [1:0] sh,
		input logic on, input logic [11:0] a, output logic [1:0] f);
		f = 2'h0;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_mode <= md;
		cmd_sh <= sh;
		cmd_link_on <= on;
		cmd_addr <= a;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		repeat (4) begin
			@(negedge mclk);
			f = f | {rd_valid_q === 1'b1, refused_q === 1'b1};
		end
		for (int i = 0; busy_q !== 1'b0; i++) begin
			if (i == 20) begin
				err_total++;
				$display("MISMATCH busy expected low seen high");
				end_sim();
			end
			@(negedge mclk);
		end
	endtask
	// register read through the receiver end
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		logic [1:0] f;
		issue(slj_op_read, slj_mode_quad, 2'h0, 1'b0, a, f);
		cmp("read answered", 8'h01, {7'h0, f[1]});
		d = rd_data_q;
	endtask
	// one-cycle sysref pulse, realign or plain event
	task automatic pulse(input logic which);
		@(posedge mclk);
		if (which) realign <= 1'b1;
		else sevent <= 1'b1;
		@(posedge mclk);
		realign <= 1'b0;
		sevent <= 1'b0;
	endtask
	// reset values; an event before link enable must not mark alignment
	task automatic s_reset();
		logic [7:0] d;
		cmp("chan enable", 8'h0f, {4'h0, chan_q});
		rd(`SLJ_OFS_CHANNEL_ENABLE_CTRL, d);
		cmp("channel_enable_ctrl reset", `SLJ_CHANNEL_ENABLE_CTRL_RST, d);
		pulse(1'b0);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("status idle", 8'h01, d);
	endtask
	// every channel arrangement, ending in quad; never both pairs off
	task automatic s_modes();
		logic [7:0] mb [4] = '{`SLJ_CH_QUAD, `SLJ_CH_DUAL_AB, `SLJ_CH_DUAL_CD, `SLJ_CH_ONE};
		logic [3:0] ce [4] = '{4'hf, 4'h3, 4'hc, 4'h1};
		logic [7:0] d;
		logic [1:0] f;
		logic red;
		for (int m = 3; m >= 0; m--) begin
			issue(slj_op_cfg, slj_mode_t'(m), 2'h0, 1'b0, 12'h0, f);
			repeat (4) @(negedge mclk);
			red = mb[m][2] | !mb[m][0] | !mb[m][1];
			cmp("chan enable", {4'h0, ce[m]}, {4'h0, chan_q});
			cmp("single mode", {7'h0, mb[m][2]}, {7'h0, one_q});
			cmp("lanes", red ? 8'((FULL_L + 1) / 2) : 8'(FULL_L), {4'h0, lane_q});
			cmp("converters", red ? 8'(FULL_M / 2) : 8'(FULL_M), {4'h0, conv_q});
			cmp("tail bits", {7'h0, red & 1'(FULL_L % 2)}, {7'h0, tail_q});
			cmp("pair swap", {7'h0, !mb[m][0] & mb[m][1]}, {7'h0, swap_q});
			rd(`SLJ_OFS_CHANNEL_ENABLE_CTRL, d);
			cmp("channel_enable_ctrl readback", mb[m], d);
		end
	endtask
	// sync header codes: reserved ones refused, sent words follow the last good one
	task automatic s_header();
		logic [1:0] codes [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
		logic [1:0] la;
		logic [1:0] f;
		logic [7:0] d;
		la = 2'h0;
		for (int i = 0; i < 4; i++) begin
			issue(slj_op_cfg, slj_mode_quad, codes[i], 1'b0, 12'h0, f);
			cmp("refused", {7'h0, codes[i][0]}, {7'h0, f[0]});
			if (!codes[i][0]) la = codes[i];
			repeat (3) @(negedge mclk);
			cmp("crc word", {7'h0, la == 2'h0}, {7'h0, crc_q});
			cmp("fec word", {7'h0, la == 2'h2}, {7'h0, fec_q});
		end
		rd(`SLJ_OFS_SH_MODE, d);
		cmp("sh readback", 8'h00, d);
		@(posedge mclk);
		is66 <= 1'b0;
		repeat (3) @(negedge mclk);
		cmp("crc outside 64b66b", 8'h00, {7'h0, crc_q});
	endtask
	// live bits and sysref flags with the link running, then lock and sync lost
	task automatic s_live();
		logic [7:0] d;
		logic [1:0] f;
		@(posedge mclk);
		spll <= 1'b1;
		rx_locked <= 1'b1;
		issue(slj_op_link, slj_mode_quad, 2'h0, 1'b1, 12'h0, f);
		repeat (6) @(negedge mclk);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("status up", 8'h65, d);
		cmp("link enable", 8'h01, {7'h0, len_q});
		cmp("calibration off", 8'h00, {7'h0, cal_q});
		pulse(1'b0);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("status multiframe_phase_set_flag", 8'h6d, d);
		pulse(1'b1);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("status realigned", 8'h7d, d);
		cmp("irq masked", 8'h00, {7'h0, irq_q});
		@(posedge mclk);
		spll <= 1'b0;
		repeat (6) @(negedge mclk);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("serializer unlocked", 8'h39, d);
		@(posedge mclk);
		rx_locked <= 1'b0;
		repeat (6) @(negedge mclk);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("sync asserted", 8'h19, d);
	endtask
	// interrupt mask and write-one clears of the sticky flags, then the last lock lost
	task automatic s_flags();
		logic [7:0] d;
		logic [1:0] f;
		issue(slj_op_flags, slj_mode_quad, 2'h3, 1'b0, `SLJ_OFS_CHANNEL_ENABLE_CTRL, f);
		cmp("flags refused", 8'h01, {7'h0, f[0]});
		issue(slj_op_flags, slj_mode_quad, 2'h3, 1'b0, `SLJ_OFS_IRQ_MASK, f);
		cmp("irq unmasked", 8'h01, {7'h0, irq_q});
		rd(`SLJ_OFS_IRQ_MASK, d);
		cmp("mask readback", 8'h18, d);
		issue(slj_op_flags, slj_mode_quad, 2'h2, 1'b0, `SLJ_OFS_LINK_STATUS, f);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("realign cleared", 8'h09, d);
		cmp("irq on align", 8'h01, {7'h0, irq_q});
		issue(slj_op_flags, slj_mode_quad, 2'h1, 1'b0, `SLJ_OFS_LINK_STATUS, f);
		pulse(1'b0);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("align cleared", 8'h01, d);
		cmp("irq cleared", 8'h00, {7'h0, irq_q});
		@(posedge mclk);
		cpll <= 1'b0;
		repeat (6) @(negedge mclk);
		rd(`SLJ_OFS_LINK_STATUS, d);
		cmp("sampling unlocked", 8'h00, d);
	endtask
	// free-running mclk, 40 ns period
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// main sequence; sampling pll locked from the start, serializer pll not
	initial begin
		{rst_b, spll, realign, sevent, cmd_valid, cmd_link_on, rx_locked} = 7'h00;
		{cpll, is66} = 2'h3;
		cmd_op = slj_op_cfg;
		cmd_mode = slj_mode_quad;
		cmd_sh = 2'h0;
		cmd_addr = 12'h000;
		err_total = 0;
		checks_done = 0;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(negedge mclk);
		s_reset();
		s_modes();
		s_header();
		s_live();
		s_flags();
		end_sim();
	end
endmodule
`default_nettype wire

// ===== verilog/slj_dev_end.sv
/*
 * converter end: link status, channel enable, sync header mode, link control
 * and interrupt mask registers, plus the frame layout they imply.
 * assumes pll lock levels and the sync line are asynchronous, sysref pulses
 * and the lane/converter counts come from logic on mclk.
 */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "slj_map.svh"
module slj_dev_end (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// link carrier
	slj_if.dev link,
	// analog lock levels, asynchronous
	input wire logic serializer_pll_lock,
	input wire logic sampling_pll_lock,
	// sysref events, one-cycle pulses on mclk
	input wire logic sysref_realign,
	input wire logic sysref_event,
	// frame setup from the mode logic
	input wire logic [3:0] full_lane_count,
	input wire logic [3:0] full_converter_count,
	input wire logic mode_is_64b66b,
	// datapath controls
	output logic [3:0] chan_enable_q,
	output logic one_channel_mode_enable_q,
	output logic link_enable_q,
	output logic cal_enable_q,
	output logic send_crc12_q,
	output logic send_fec_q,
	// interrupt
	output logic irq_q
);
	import slj_pkg::*;

	// address match, used by every decode below
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	// lanes after halving, rounded up
	function automatic logic [3:0] half_up(input logic [3:0] n);
		logic [4:0] s;
		s = {1'b0, n} + 5'h01;
		half_up = s[4:1];
	endfunction

	logic [2:0] meta_q; // first stage: sync_n, spll, cpll
	logic [2:0] live_q; // second stage, the only readable copy
	logic [7:0] channel_enable_ctrl_q; // channel_enable_ctrl, reserved bits kept as written
	logic [7:0] sh_mode_q; // sync_header_mode_ctrl
	logic [7:0] ctrl_q; // link and calibration enables
	logic [7:0] mask_q; // interrupt mask, same layout as link_status
	logic realign_q; // sticky phase-shifted flag
	logic align_q; // sticky multiframe_phase_set_flag
	logic armed_q; // waiting for the first sysref after enable
	logic link_en_d1_q; // previous link enable, for the rising edge
	logic link_up_q; // link established
	logic [7:0] status_w; // assembled status byte
	logic wr_status; // write to link_status this cycle
	logic wr_ch; // write to channel_enable_ctrl
	logic wr_sh; // write to sync_header_mode_ctrl
	logic wr_ctrl; // write to link control
	logic wr_mask; // write to interrupt mask
	logic reduced; // one pair is off, frame shrinks
	logic single; // one channel mode selected
	logic pair_a; // first pair enable
	logic pair_c; // second pair enable

	// write decodes
	assign wr_status = link.reg_wr & hit(link.reg_addr, `SLJ_OFS_LINK_STATUS);
	assign wr_ch = link.reg_wr & hit(link.reg_addr, `SLJ_OFS_CHANNEL_ENABLE_CTRL);
	assign wr_sh = link.reg_wr & hit(link.reg_addr, `SLJ_OFS_SH_MODE);
	assign wr_ctrl = link.reg_wr & hit(link.reg_addr, `SLJ_OFS_LINK_CTRL);
	assign wr_mask = link.reg_wr & hit(link.reg_addr, `SLJ_OFS_IRQ_MASK);

	// channel field views
	assign single = channel_enable_ctrl_q[`SLJ_CH_SINGLE];
	assign pair_a = channel_enable_ctrl_q[`SLJ_CH_FIRST];
	assign pair_c = channel_enable_ctrl_q[`SLJ_CH_SECOND];
	// single mode counts as a disabled pair too, since c and d are off
	assign reduced = single | ~pair_a | ~pair_c;

	// status byte; reserved bits read zero, live bits never stored from writes
	always_comb begin
		status_w = 8'h00;
		status_w[`SLJ_ST_LINK_UP] = link_up_q;
		status_w[`SLJ_ST_SYNC] = live_q[2];
		status_w[`SLJ_ST_REALIGN] = realign_q;
		status_w[`SLJ_ST_ALIGN] = align_q;
		status_w[`SLJ_ST_SPLL] = live_q[1];
		status_w[`SLJ_ST_CPLL] = live_q[0];
	end

	// two-stage synchronisers for the pin and analog levels
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 3'h0;
			live_q <= 3'h0;
		end else begin
			meta_q <= {link.sync_n, serializer_pll_lock, sampling_pll_lock};
			live_q <= meta_q;
		end
	end

	// control registers; status writes only reach the sticky flags
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			channel_enable_ctrl_q <= `SLJ_CHANNEL_ENABLE_CTRL_RST;
			sh_mode_q <= `SLJ_SH_MODE_RST;
			ctrl_q <= `SLJ_LINK_CTRL_RST;
			mask_q <= `SLJ_IRQ_MASK_RST;
		end else begin
			if (wr_ch) begin
				channel_enable_ctrl_q <= link.reg_wdata;
			end
			if (wr_sh) begin
				sh_mode_q <= link.reg_wdata;
			end
			if (wr_ctrl) begin
				ctrl_q <= link.reg_wdata;
			end
			if (wr_mask) begin
				mask_q <= link.reg_wdata;
			end
		end
	end

	// link up: enabled, sync released by the receiver, serializer locked
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link_up_q <= 1'b0;
		end else begin
			link_up_q <= ctrl_q[`SLJ_CTRL_LINK_EN] & live_q[2] & live_q[1];
		end
	end

	// realign flag; a new event beats a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			realign_q <= 1'b0;
		end else if (sysref_realign) begin
			realign_q <= 1'b1;
		end else if (wr_status & link.reg_wdata[`SLJ_ST_REALIGN]) begin
			realign_q <= 1'b0;
		end
	end

	// arm on the enable edge, set the flag at the first sysref that follows
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link_en_d1_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			link_en_d1_q <= ctrl_q[`SLJ_CTRL_LINK_EN];
			if (!ctrl_q[`SLJ_CTRL_LINK_EN]) begin
				armed_q <= 1'b0;
			end else if (!link_en_d1_q) begin
				armed_q <= 1'b1;
			end else if (sysref_event) begin
				armed_q <= 1'b0;
			end
		end
	end

	// multiframe phase flag; only the armed sysref sets it, set beats clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			align_q <= 1'b0;
		end else if (sysref_event & armed_q & link_en_d1_q) begin
			align_q <= 1'b1;
		end else if (wr_status & link.reg_wdata[`SLJ_ST_ALIGN]) begin
			align_q <= 1'b0;
		end
	end

	// read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link.reg_rdata <= 8'h00;
		end else if (!link.reg_rd) begin
			link.reg_rdata <= 8'h00;
		end else if (hit(link.reg_addr, `SLJ_OFS_LINK_STATUS)) begin
			link.reg_rdata <= status_w;
		end else if (hit(link.reg_addr, `SLJ_OFS_CHANNEL_ENABLE_CTRL)) begin
			link.reg_rdata <= channel_enable_ctrl_q;
		end else if (hit(link.reg_addr, `SLJ_OFS_SH_MODE)) begin
			link.reg_rdata <= sh_mode_q;
		end else if (hit(link.reg_addr, `SLJ_OFS_LINK_CTRL)) begin
			link.reg_rdata <= ctrl_q;
		end else if (hit(link.reg_addr, `SLJ_OFS_IRQ_MASK)) begin
			link.reg_rdata <= mask_q;
		end else begin
			// unmapped addresses read zero
			link.reg_rdata <= 8'h00;
		end
	end

	// per-channel enables {d, c, b, a}
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			chan_enable_q <= 4'h0;
			one_channel_mode_enable_q <= 1'b0;
		end else if (single) begin
			// only a runs; b goes with c and d even though a is its pair
			chan_enable_q <= {3'h0, pair_a};
			one_channel_mode_enable_q <= 1'b1;
		end else begin
			chan_enable_q <= {pair_c, pair_c, pair_a, pair_a};
			one_channel_mode_enable_q <= 1'b0;
		end
	end

	// frame layout the receiver has to match
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link.lane_count <= 4'h0;
			link.conv_count <= 4'h0;
			link.tail_bits <= 1'b0;
			link.pair_swap <= 1'b0;
		end else begin
			link.lane_count <= reduced ? half_up(full_lane_count) : full_lane_count;
			link.conv_count <= reduced ? {1'b0, full_converter_count[3:1]} :
				full_converter_count;
			link.tail_bits <= reduced & full_lane_count[0];
			link.pair_swap <= ~single & ~pair_a & pair_c;
		end
	end

	// enables and sync word choice; reserved codes send neither word
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link_enable_q <= 1'b0;
			cal_enable_q <= 1'b0;
			send_crc12_q <= 1'b0;
			send_fec_q <= 1'b0;
		end else begin
			link_enable_q <= ctrl_q[`SLJ_CTRL_LINK_EN];
			cal_enable_q <= ctrl_q[`SLJ_CTRL_CAL_EN];
			send_crc12_q <= mode_is_64b66b & (sh_mode_q[1:0] == `SLJ_SH_CRC12);
			send_fec_q <= mode_is_64b66b & (sh_mode_q[1:0] == `SLJ_SH_FEC);
		end
	end

	// level interrupt from the unmasked sticky flags
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (realign_q & mask_q[`SLJ_ST_REALIGN]) |
				(align_q & mask_q[`SLJ_ST_ALIGN]);
		end
	end
endmodule
`default_nettype wire

// ===== verilog/slj_if.sv
/*
 * carrier between the converter end and the receiver end: register host port,
 * the sync request line and the frame layout the converter end announces.
 * assumes both ends run on one mclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface slj_if;
	// register host port
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	// sync request, low asserts
	logic sync_n;
	// frame layout
	logic [3:0] lane_count;
	logic [3:0] conv_count;
	logic tail_bits;
	logic pair_swap;

	modport dev (
		input reg_addr, reg_wdata, reg_wr, reg_rd, sync_n,
		output reg_rdata, lane_count, conv_count, tail_bits, pair_swap
	);
	modport rx (
		output reg_addr, reg_wdata, reg_wr, reg_rd, sync_n,
		input reg_rdata, lane_count, conv_count, tail_bits, pair_swap
	);
endinterface
`default_nettype wire

// ===== verilog/slj_map.svh
/*
 * register offsets, field positions, reset values and codes of the serial link
 * status and channel enable bank.
 * assumes a 12-bit byte address and 8-bit register data on the host port.
 */
`ifndef SLJ_MAP_SVH
`define SLJ_MAP_SVH

// host port widths
`define SLJ_ADDR_W 12
`define SLJ_DATA_W 8

// register offsets
`define SLJ_OFS_LINK_STATUS 12'h208
`define SLJ_OFS_CHANNEL_ENABLE_CTRL 12'h209
`define SLJ_OFS_SH_MODE 12'h20f
`define SLJ_OFS_LINK_CTRL 12'h2f0
`define SLJ_OFS_IRQ_MASK 12'h2f1

// link_status field positions
`define SLJ_ST_LINK_UP 6
`define SLJ_ST_SYNC 5
`define SLJ_ST_REALIGN 4
`define SLJ_ST_ALIGN 3
`define SLJ_ST_SPLL 2
`define SLJ_ST_CPLL 0

// channel_enable_ctrl field positions
`define SLJ_CH_SINGLE 2
`define SLJ_CH_SECOND 1
`define SLJ_CH_FIRST 0

// link control field positions
`define SLJ_CTRL_LINK_EN 0
`define SLJ_CTRL_CAL_EN 1

// reset values
`define SLJ_CHANNEL_ENABLE_CTRL_RST 8'h03
`define SLJ_SH_MODE_RST 8'h00
`define SLJ_LINK_CTRL_RST 8'h00
`define SLJ_IRQ_MASK_RST 8'h00

// channel enable values written by the receiver end
`define SLJ_CH_QUAD 8'h03
`define SLJ_CH_DUAL_AB 8'h01
`define SLJ_CH_DUAL_CD 8'h02
`define SLJ_CH_ONE 8'h05

// sync header codes
`define SLJ_SH_CRC12 2'h0
`define SLJ_SH_FEC 2'h2

`endif

// ===== verilog/slj_pkg.sv
/*
 * types shared by both ends of the serial link status bank.
 * assumes slj_map.svh supplies the numeric constants.
 */
`default_nettype none
package slj_pkg;
	// channel arrangement the receiver end asks for
	typedef enum logic [1:0] {
		slj_mode_quad,
		slj_mode_dual_ab,
		slj_mode_dual_cd,
		slj_mode_single
	} slj_mode_t;
	// receiver end command kinds
	typedef enum logic [1:0] {
		slj_op_cfg,
		slj_op_link,
		slj_op_read,
		slj_op_flags
	} slj_op_t;
	// receiver end sequencer states
	typedef enum logic [2:0] {
		slj_st_idle,
		slj_st_chen,
		slj_st_shm,
		slj_st_on,
		slj_st_rd1,
		slj_st_rd2
	} slj_state_t;
endpackage
`default_nettype wire

// ===== verilog/slj_rx_end.sv
/*
 * receiver end: drives the sync request, sequences configuration writes into
 * the converter end with the link held off, reads registers on request and
 * captures the announced frame layout.
 * assumes the user command port and rx_locked are on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "slj_map.svh"
module slj_rx_end (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// link carrier
	slj_if.rx link,
	// user command port
	input wire logic cmd_valid,
	input wire slj_pkg::slj_op_t cmd_op,
	input wire slj_pkg::slj_mode_t cmd_mode,
	input wire logic [1:0] cmd_sync_header,
	input wire logic cmd_link_on,
	input wire logic [11:0] cmd_addr,
	// receiver datapath state
	input wire logic rx_locked,
	// user answers
	output logic busy_q,
	output logic refused_q,
	output logic rd_valid_q,
	output logic [7:0] rd_data_q,
	// captured frame layout
	output logic [3:0] lane_count_q,
	output logic [3:0] conv_count_q,
	output logic tail_bits_q,
	output logic pair_swap_q
);
	import slj_pkg::*;

	// channel enable byte per mode; no mode clears both pairs
	function automatic logic [7:0] ch_value(input slj_mode_t m);
		case (m)
			slj_mode_dual_ab: ch_value = `SLJ_CH_DUAL_AB;
			slj_mode_dual_cd: ch_value = `SLJ_CH_DUAL_CD;
			slj_mode_single: ch_value = `SLJ_CH_ONE;
			default: ch_value = `SLJ_CH_QUAD;
		endcase
	endfunction

	slj_state_t state_q; // sequencer state
	logic link_on_q; // link enable the user wants restored
	logic [7:0] ch_hold_q; // pending channel enable byte
	logic [7:0] sh_hold_q; // pending sync header byte

	// sequencer: link off, channels, header, link back; one strobe per cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= slj_st_idle;
			link_on_q <= 1'b0;
			ch_hold_q <= `SLJ_CHANNEL_ENABLE_CTRL_RST;
			sh_hold_q <= `SLJ_SH_MODE_RST;
			link.reg_addr <= 12'h000;
			link.reg_wdata <= 8'h00;
			link.reg_wr <= 1'b0;
			link.reg_rd <= 1'b0;
			busy_q <= 1'b0;
			refused_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			link.reg_wr <= 1'b0;
			link.reg_rd <= 1'b0;
			refused_q <= 1'b0;
			rd_valid_q <= 1'b0;
			case (state_q)
				slj_st_idle: begin
					if (cmd_valid && cmd_op == slj_op_cfg && !cmd_sync_header[0]) begin
						// calibration and link off first
						link.reg_addr <= `SLJ_OFS_LINK_CTRL;
						link.reg_wdata <= 8'h00;
						link.reg_wr <= 1'b1;
						ch_hold_q <= ch_value(cmd_mode);
						sh_hold_q <= {6'h00, cmd_sync_header};
						state_q <= slj_st_chen;
						busy_q <= 1'b1;
					end else if (cmd_valid && cmd_op == slj_op_link) begin
						link.reg_addr <= `SLJ_OFS_LINK_CTRL;
						link.reg_wdata <= {7'h00, cmd_link_on};
						link.reg_wr <= 1'b1;
						link_on_q <= cmd_link_on;
					end else if (cmd_valid && cmd_op == slj_op_read) begin
						link.reg_addr <= cmd_addr;
						link.reg_rd <= 1'b1;
						state_q <= slj_st_rd1;
						busy_q <= 1'b1;
					end else if (cmd_valid && cmd_op == slj_op_flags &&
						(cmd_addr == `SLJ_OFS_LINK_STATUS || cmd_addr == `SLJ_OFS_IRQ_MASK)) begin
						// flag bits only, so channel setup can never bypass the link-off walk
						link.reg_addr <= cmd_addr;
						link.reg_wdata <= {3'h0, cmd_sync_header, 3'h0};
						link.reg_wr <= 1'b1;
					end else if (cmd_valid) begin
						// reserved header codes and flag writes to other addresses
						refused_q <= 1'b1;
					end
				end
				slj_st_chen: begin
					refused_q <= cmd_valid;
					link.reg_addr <= `SLJ_OFS_CHANNEL_ENABLE_CTRL;
					link.reg_wdata <= ch_hold_q;
					link.reg_wr <= 1'b1;
					state_q <= slj_st_shm;
				end
				slj_st_shm: begin
					refused_q <= cmd_valid;
					link.reg_addr <= `SLJ_OFS_SH_MODE;
					link.reg_wdata <= sh_hold_q;
					link.reg_wr <= 1'b1;
					state_q <= slj_st_on;
				end
				slj_st_on: begin
					refused_q <= cmd_valid;
					link.reg_addr <= `SLJ_OFS_LINK_CTRL;
					link.reg_wdata <= {7'h00, link_on_q};
					link.reg_wr <= 1'b1;
					state_q <= slj_st_idle;
					busy_q <= 1'b0;
				end
				slj_st_rd1: begin
					refused_q <= cmd_valid;
					state_q <= slj_st_rd2;
				end
				slj_st_rd2: begin
					refused_q <= cmd_valid;
					rd_data_q <= link.reg_rdata;
					rd_valid_q <= 1'b1;
					state_q <= slj_st_idle;
					busy_q <= 1'b0;
				end
				default: begin
					state_q <= slj_st_idle;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	// sync request held low until the link is wanted and the receiver locks
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link.sync_n <= 1'b0;
		end else begin
			link.sync_n <= link_on_q & rx_locked;
		end
	end

	// frame layout copy for the deframer
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lane_count_q <= 4'h0;
			conv_count_q <= 4'h0;
			tail_bits_q <= 1'b0;
			pair_swap_q <= 1'b0;
		end else begin
			lane_count_q <= link.lane_count;
			conv_count_q <= link.conv_count;
			tail_bits_q <= link.tail_bits;
			pair_swap_q <= link.pair_swap;
		end
	end
endmodule
`default_nettype wire
